// file: design/cls_consts.svh
// Purpose: constants of the link status and sideband block
// Assumes: 32-bit register words, byte addresses
// Notes:   the 10 us cycle count derives from the clock period; init-clock counts are fixed
`ifndef CLS_CONSTS_SVH
`define CLS_CONSTS_SVH
`define CLS_CLK_PERIOD_PS   5000
`define CLS_CC_PERIOD_US    10
`define CLS_CC_CLK_CYCLES   ((`CLS_CC_PERIOD_US * 1000000) / `CLS_CLK_PERIOD_PS)
`define CLS_CC_INIT_CLKS    10000
`define CLS_HOTPLUG_BITS    26
`define CLS_SYNC_W          8
`define CLS_ADDR_CTRL       8'h00
`define CLS_ADDR_STATUS     8'h04
`define CLS_ADDR_FAULT      8'h08
`define CLS_CTRL_RESET      2'h1
`define CLS_CTRL_ENABLE     0
`define CLS_CTRL_FORCEINIT  1
`define CLS_FAULT_LINK      0
`define CLS_FAULT_MULTIBIT  1
`define CLS_FAULT_CFG       2
`define CLS_RESP_OKAY       2'h0
`define CLS_RESP_SLVERR     2'h2
`endif

// file: design/cls_pkg.sv
// Purpose: types of the link status and sideband block
// Assumes: constants come from cls_consts.svh
// Notes:   fault flags travel as one packed struct
package cls_pkg;
   // link-detect machine
   typedef enum logic [2:0] {
      CLS_IDLE,
      CLS_WAIT_LOCK,
      CLS_DETECT,
      CLS_SYNC,
      CLS_FAULT
   } cls_state_t;
   // sticky fault indications
   typedef struct packed {
      logic cfgMismatch;
      logic multibit;
      logic linkFault;
   } cls_fault_t;
endpackage

// file: design/cls_sideband.sv
// Purpose: link status, fault interrupts, transceiver sideband and level-interrupt forwarding
// Assumes: all inputs synchronous to clk, but sideband and peer levels are resynchronised anyway
// Notes:   registers over AXI4-Lite; faults are sticky until cleared or reset
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "cls_consts.svh"

//Contract
//- differential data lanes only when enabled
//- differential link clocks only when enabled
//- clock-compensation pulse about every 10 us; code pulses every CC_INIT_CLKS init clocks instead
//- transceiver init output follows init input
//- not-locked input means user clock unstable
//- link-up high while machine synchronized
//- link-up low on any reset or desync
//- master only: link fault on slave reset
//- multibit fault when multiple bits errored
//- parallel interface: multibit means deskew failed
//- serial only: configuration mismatch fault
//- forwarded level updates only on change
//- interrupts and status synchronous to clk
//- after link-up, pulse every 10000 init clocks
//- link-up starts only locked and channel up; with USE_XCVR clear the code skips the lock and channel-up checks
//- hot-plug counter overflow asserts transceiver init
module cls_sideband import cls_pkg::*; #(
   parameter int M            = 8,
   parameter bit USE_DIFF_IO  = 1'b0,
   parameter bit USE_DIFF_CLK = 1'b0,
   parameter bit IS_MASTER    = 1'b1,
   parameter bit USE_XCVR     = 1'b0,
   parameter int CC_INIT_CLKS = `CLS_CC_INIT_CLKS,
   parameter int HOTPLUG_BITS = `CLS_HOTPLUG_BITS
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         masterRstN,
   input  wire logic         slaveRstN,
   // parallel lanes, core side
   input  wire logic [M-1:0] txData,
   input  wire logic         txClk,
   output logic [M-1:0]      rxData,
   output logic              rxClk,
   // parallel lanes, pin side
   output logic [M-1:0]      txDataSe,
   output logic [M-1:0]      txDataP,
   output logic [M-1:0]      txDataN,
   output logic              txClkSe,
   output logic              txClkP,
   output logic              txClkN,
   input  wire logic [M-1:0] rxDataSe,
   input  wire logic [M-1:0] rxDataP,
   input  wire logic         rxClkSe,
   input  wire logic         rxClkP,
   // transceiver sideband
   input  wire logic         xcvrInitIn,
   output logic              xcvrInitOut,
   input  wire logic         xcvrInitClk,
   input  wire logic         xcvrNotLocked,
   input  wire logic         xcvrChannelUp,
   output logic              xcvrLogicReset,
   output logic              clkCompPulseOut,
   // link events from the peer
   input  wire logic         peerReady,
   input  wire logic         peerCfgBad,
   input  wire logic         multiBitErr,
   input  wire logic         peerIrqRx,
   output logic              peerIrqTx,
   // status and interrupts
   output logic              linkUpOut,
   output logic              linkFaultIrq,
   output logic              multibitFaultIrq,
   output logic              cfgMismatchIrq,
   input  wire logic         fwdLevelIrqIn,
   input  wire logic         revLevelIrqIn,
   output logic              fwdLevelIrqOut,
   output logic              revLevelIrqOut,
   // axi4-lite slave
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready
);
   localparam int CC_W = $clog2(CC_INIT_CLKS);
   localparam logic [CC_W-1:0] CC_LAST = CC_W'(CC_INIT_CLKS - 1);

   cls_state_t              state_reg;
   cls_state_t              state_next;
   cls_fault_t              fault_reg;
   logic [`CLS_SYNC_W-1:0]  syncA_reg;
   logic [`CLS_SYNC_W-1:0]  syncB_reg;
   logic                    initClkD_reg;
   logic [CC_W-1:0]         ccCount_reg;
   logic [HOTPLUG_BITS-1:0] hotplug_reg;
   logic                    hotplugWrap_reg;
   logic                    linkUpD_reg;
   logic [1:0]              ctrl_reg;
   logic                    awHeld_reg;
   logic                    wHeld_reg;
   logic [7:0]              awAddr_reg;
   logic [31:0]             wData_reg;
   logic                    irqFwd_reg;
   logic                    irqRev_reg;
   logic                    notLocked;
   logic                    chanUp;
   logic                    initIn;
   logic                    initClkS;
   logic                    peerIrqS;
   logic                    slaveRstS;
   logic                    masterRstS;
   logic                    localIrqS;
   logic                    bothOut;
   logic                    initClkRise;
   logic                    doWrite;
   logic                    faultClr;
   logic                    wStrb0_reg;
   logic                    wStrb0;
   cls_fault_t              faultSet;

   // lane selection is static, so plain muxes on the parameters suffice
   assign txDataSe = USE_DIFF_IO ? '0 : txData;
   assign txDataP  = USE_DIFF_IO ? txData : '0;
   assign txDataN  = USE_DIFF_IO ? ~txData : '0;
   assign rxData   = USE_DIFF_IO ? rxDataP : rxDataSe;
   assign txClkSe  = USE_DIFF_CLK ? 1'b0 : txClk;
   assign txClkP   = USE_DIFF_CLK ? txClk : 1'b0;
   assign txClkN   = USE_DIFF_CLK ? ~txClk : 1'b0;
   assign rxClk    = USE_DIFF_CLK ? rxClkP : rxClkSe;

   // two-stage synchronisers; only the second stage is read
   always_ff @(posedge clk) begin
      if (srst) begin
         syncA_reg <= '0;
         syncB_reg <= '0;
      end else begin
         syncA_reg <= {IS_MASTER ? fwdLevelIrqIn : revLevelIrqIn, masterRstN, slaveRstN, peerIrqRx,
                       xcvrInitClk, xcvrInitIn, xcvrChannelUp, xcvrNotLocked};
         syncB_reg <= syncA_reg;
      end
   end
   assign notLocked  = syncB_reg[0];
   assign chanUp     = syncB_reg[1];
   assign initIn     = syncB_reg[2];
   assign initClkS   = syncB_reg[3];
   assign peerIrqS   = syncB_reg[4];
   assign slaveRstS  = syncB_reg[5];
   assign masterRstS = syncB_reg[6];
   assign localIrqS  = syncB_reg[7];
   assign bothOut    = slaveRstS && masterRstS;

   // link-detect machine
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CLS_IDLE: begin
            if (bothOut && ctrl_reg[`CLS_CTRL_ENABLE])
               state_next = CLS_WAIT_LOCK;
         end
         CLS_WAIT_LOCK: begin
            // an unlocked transceiver means its user clock is unstable
            if (!bothOut)
               state_next = CLS_IDLE;
            else if (!USE_XCVR || (!notLocked && chanUp))
               state_next = CLS_DETECT;
         end
         CLS_DETECT: begin
            if (!bothOut)
               state_next = CLS_IDLE;
            else if ((USE_XCVR && peerCfgBad) || multiBitErr)
               state_next = CLS_FAULT;
            else if (peerReady)
               state_next = CLS_SYNC;
         end
         CLS_SYNC: begin
            if (!bothOut)
               state_next = CLS_IDLE;
            else if (USE_XCVR && (notLocked || !chanUp))
               state_next = CLS_WAIT_LOCK;
         end
         CLS_FAULT: begin
            // recovery only through a reset of either end
            if (!bothOut)
               state_next = CLS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst)
         state_reg <= CLS_IDLE;
      else
         state_reg <= state_next;
   end

   // link-up is a registered decode of the synchronized state
   always_ff @(posedge clk) begin
      if (srst) begin
         linkUpOut   <= 1'b0;
         linkUpD_reg <= 1'b0;
      end else begin
         linkUpOut   <= (state_next == CLS_SYNC) && bothOut;
         linkUpD_reg <= linkUpOut;
      end
   end

   // fault sources; multibit during deskew marks a failed deskew on parallel lanes
   always_comb begin
      faultSet.linkFault   = IS_MASTER && linkUpD_reg && !slaveRstS;
      faultSet.multibit    = multiBitErr && (state_reg == CLS_DETECT || state_reg == CLS_SYNC);
      faultSet.cfgMismatch = USE_XCVR && peerCfgBad && state_reg == CLS_DETECT;
   end

   // sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (srst)
         fault_reg <= '0;
      else
         fault_reg <= faultSet | (faultClr ? (fault_reg & ~cls_fault_t'(wData_reg[2:0])) : fault_reg);
   end
   assign linkFaultIrq     = fault_reg.linkFault;
   assign multibitFaultIrq = fault_reg.multibit;
   assign cfgMismatchIrq   = fault_reg.cfgMismatch;

   // compensation pulse counts init-clock edges, CC_INIT_CLKS rising edges apart, only while linked
   assign initClkRise = initClkS && !initClkD_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         initClkD_reg    <= 1'b0;
         ccCount_reg     <= '0;
         clkCompPulseOut <= 1'b0;
      end else begin
         initClkD_reg    <= initClkS;
         clkCompPulseOut <= 1'b0;
         if (!linkUpOut)
            ccCount_reg <= '0;
         else if (initClkRise) begin
            if (ccCount_reg == CC_LAST) begin
               ccCount_reg     <= '0;
               clkCompPulseOut <= 1'b1;
            end else
               ccCount_reg <= ccCount_reg + 1'b1;
         end
      end
   end

   // hot-plug counter runs while the channel is down and wraps to request init
   always_ff @(posedge clk) begin
      if (srst) begin
         hotplug_reg     <= '0;
         hotplugWrap_reg <= 1'b0;
      end else begin
         hotplugWrap_reg <= 1'b0;
         if (!USE_XCVR || chanUp)
            hotplug_reg <= '0;
         else begin
            hotplug_reg <= hotplug_reg + 1'b1;
            if (&hotplug_reg)
               hotplugWrap_reg <= 1'b1;
         end
      end
   end

   // transceiver init and interconnect reset
   always_ff @(posedge clk) begin
      if (srst) begin
         xcvrInitOut    <= 1'b0;
         xcvrLogicReset <= 1'b1;
      end else begin
         xcvrInitOut    <= initIn || hotplugWrap_reg || ctrl_reg[`CLS_CTRL_FORCEINIT];
         xcvrLogicReset <= initIn || !bothOut;
      end
   end

   // level forwarding: the output only moves when the peer level changes
   always_ff @(posedge clk) begin
      if (srst) begin
         peerIrqTx  <= 1'b0;
         irqFwd_reg <= 1'b0;
         irqRev_reg <= 1'b0;
      end else begin
         peerIrqTx <= localIrqS;
         if (linkUpOut && peerIrqS != (IS_MASTER ? irqRev_reg : irqFwd_reg)) begin
            if (IS_MASTER)
               irqRev_reg <= peerIrqS;
            else
               irqFwd_reg <= peerIrqS;
         end
      end
   end
   assign fwdLevelIrqOut = irqFwd_reg;
   assign revLevelIrqOut = irqRev_reg;

   // write channel: address and data taken in either order, response after both
   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
   assign doWrite       = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign faultClr      = doWrite && awAddr_reg == `CLS_ADDR_FAULT && wStrb0;
   assign wStrb0        = wStrb0_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         awHeld_reg   <= 1'b0;
         wHeld_reg    <= 1'b0;
         awAddr_reg   <= '0;
         wData_reg    <= '0;
         wStrb0_reg   <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CLS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg  <= 1'b1;
            wData_reg  <= s_axi_wdata;
            wStrb0_reg <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            awHeld_reg   <= 1'b0;
            wHeld_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_reg == `CLS_ADDR_CTRL || awAddr_reg == `CLS_ADDR_FAULT) ?
                            `CLS_RESP_OKAY : `CLS_RESP_SLVERR;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // control register steers link enable and forced transceiver init
   always_ff @(posedge clk) begin
      if (srst)
         ctrl_reg <= `CLS_CTRL_RESET;
      else if (doWrite && awAddr_reg == `CLS_ADDR_CTRL && wStrb0)
         ctrl_reg <= wData_reg[1:0];
   end

   // read channel: one cycle to the answer, held until taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `CLS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `CLS_RESP_OKAY;
         unique case (s_axi_araddr)
            `CLS_ADDR_CTRL:   s_axi_rdata <= {30'h0, ctrl_reg};
            `CLS_ADDR_STATUS: s_axi_rdata <= {26'h0, chanUp, notLocked, state_reg, linkUpOut};
            `CLS_ADDR_FAULT:  s_axi_rdata <= {29'h0, fault_reg};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= `CLS_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule // cls_sideband

// file: tb/cls_sideband_props.sv
// Purpose: concurrent checks on the ports of the sideband block
// Assumes: one clock domain, srst synchronous and active high
// Notes:   bound to every cls_sideband instance below
`timescale 1ns/100ps
module cls_sideband_props (
   // clock and resets
   input wire logic clk,
   input wire logic srst,
   input wire logic masterRstN,
   input wire logic slaveRstN,
   // watched inputs
   input wire logic xcvrInitIn,
   input wire logic peerReady,
   input wire logic peerCfgBad,
   input wire logic multiBitErr,
   input wire logic fwdLevelIrqIn,
   // watched outputs
   input wire logic xcvrInitOut,
   input wire logic xcvrLogicReset,
   input wire logic clkCompPulseOut,
   input wire logic peerIrqTx,
   input wire logic linkUpOut,
   input wire logic linkFaultIrq,
   input wire logic multibitFaultIrq,
   input wire logic cfgMismatchIrq,
   input wire logic revLevelIrqOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // multi-step causes; resynchronisers add up to three edges of delay
   sequence s_initHeld; xcvrInitIn [*4]; endsequence
   sequence s_slaveDrop; $fell(slaveRstN) && linkUpOut; endsequence
   sequence s_lvlHeld; $rose(fwdLevelIrqIn) ##1 fwdLevelIrqIn [*4]; endsequence
   property p_rstQuiet;
      $fell(srst) |-> !linkUpOut && !linkFaultIrq && !multibitFaultIrq && !cfgMismatchIrq && xcvrLogicReset;
   endproperty
   property p_initFwd; s_initHeld |-> xcvrInitOut; endproperty
   property p_linkRise; $rose(linkUpOut) |-> $past(peerReady) && masterRstN && slaveRstN; endproperty
   property p_linkDrop; s_slaveDrop |-> ##[1:6] !linkUpOut; endproperty
   property p_linkFault; s_slaveDrop |-> ##[1:6] linkFaultIrq; endproperty
   property p_multibit; multiBitErr && linkUpOut |=> multibitFaultIrq; endproperty
   property p_cfg; $rose(cfgMismatchIrq) |-> $past(peerCfgBad) && !$past(linkUpOut); endproperty
   property p_ccPulse; clkCompPulseOut |=> !clkCompPulseOut [*8]; endproperty
   property p_fwdOnly; $changed(revLevelIrqOut) |-> $past(linkUpOut); endproperty
   property p_txLevel; s_lvlHeld |-> peerIrqTx; endproperty
   a_rstQuiet: assert property (p_rstQuiet) else $error("outputs active after reset");
   a_initFwd: assert property (p_initFwd) else $error("init request not forwarded");
   a_linkRise: assert property (p_linkRise) else $error("link up without peer");
   a_linkDrop: assert property (p_linkDrop) else $error("link up kept in reset");
   a_linkFault: assert property (p_linkFault) else $error("link fault missing");
   a_multibit: assert property (p_multibit) else $error("multibit fault missing");
   a_cfg: assert property (p_cfg) else $error("config fault without cause");
   a_ccPulse: assert property (p_ccPulse) else $error("compensation pulse too close");
   a_fwdOnly: assert property (p_fwdOnly) else $error("level moved while link down");
   a_txLevel: assert property (p_txLevel) else $error("local level not sent");
endmodule // cls_sideband_props

bind cls_sideband cls_sideband_props i_props (.clk, .srst, .masterRstN, .slaveRstN, .xcvrInitIn, .peerReady,
   .peerCfgBad, .multiBitErr, .fwdLevelIrqIn, .xcvrInitOut, .xcvrLogicReset, .clkCompPulseOut, .peerIrqTx,
   .linkUpOut, .linkFaultIrq, .multibitFaultIrq, .cfgMismatchIrq, .revLevelIrqOut);

// file: tb/cls_xcvr_peer.sv
// Purpose: behavioural transceiver and peer bridge facing the block
// Assumes: bench controls lock, config fault, bit errors and peer level
// Notes:   channel up delay is short or long to test both pacings
`timescale 1ns/100ps
module cls_xcvr_peer (
   // clock and bench controls
   input wire logic clk,
   input wire logic lockOk,
   input wire logic slow,
   input wire logic badCfg,
   input wire logic bitErr,
   input wire logic irqLvl,
   // transceiver and peer side
   input wire logic xcvrLogicReset,
   output logic     xcvrInitClk,
   output logic     xcvrNotLocked,
   output logic     xcvrChannelUp,
   output logic     peerReady,
   output logic     peerCfgBad,
   output logic     multiBitErr,
   output logic     peerIrqRx
);
   logic [2:0] div = 3'h0;
   logic [4:0] upCnt = 5'h0;
   // free-running init clock, eight system clocks a period, below clk/4
   always_ff @(posedge clk) div <= div + 3'h1;
   assign xcvrInitClk = div[2];
   // interconnect reset drops the channel, as the real core does
   always_ff @(posedge clk) begin
      if (xcvrLogicReset || !lockOk) upCnt <= 5'h0;
      else if (upCnt != 5'h1f) upCnt <= upCnt + 5'h1;
   end
   // peer answers ready only when configured alike
   assign xcvrNotLocked = !lockOk;
   assign xcvrChannelUp = upCnt > (slow ? 5'h14 : 5'h02);
   assign peerReady = xcvrChannelUp && !badCfg;
   assign peerCfgBad = xcvrChannelUp && badCfg;
   assign multiBitErr = bitErr;
   assign peerIrqRx = irqLvl;
endmodule // cls_xcvr_peer

// file: tb/test_cls_sideband.sv
// Purpose: self-checking bench for the sideband block
// Assumes: master build with serial transceiver and shortened counts
// Notes:   outputs are sampled on the falling edge where they are settled
`timescale 1ns/100ps
`include "cls_consts.svh"
module test_cls_sideband;
   logic clk = 1'b0, srst = 1'b1, masterRstN = 1'b0, slaveRstN = 1'b0, xcvrInitIn = 1'b0;
   logic fwdLevelIrqIn = 1'b0, revLevelIrqIn = 1'b0, txClk = 1'b1, rxClkSe = 1'b1, rxClkP = 1'b0;
   logic lockOk = 1'b0, slow = 1'b1, badCfg = 1'b0, bitErr = 1'b0, irqLvl = 1'b0;
   logic [3:0] txData = 4'ha, rxDataSe = 4'h5, rxDataP = 4'ha, s_axi_wstrb = 4'hf, rxData, txDataSe, txDataP;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic rxClk, txClkSe, txClkP, xcvrInitOut, xcvrLogicReset, clkCompPulseOut, peerIrqTx, linkUpOut;
   logic linkFaultIrq, multibitFaultIrq, cfgMismatchIrq, revLevelIrqOut, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] txDataN;
   logic txClkN, fwdLevelIrqOut;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic xcvrInitClk, xcvrNotLocked, xcvrChannelUp, peerReady, peerCfgBad, multiBitErr, peerIrqRx;
   int badCount = 0, totalChecks = 0;
   wire logic [8:0] obs = {xcvrLogicReset, xcvrInitOut, clkCompPulseOut, cfgMismatchIrq, linkFaultIrq,
                           multibitFaultIrq, linkUpOut, revLevelIrqOut, peerIrqTx};
   cls_sideband #(.M(4), .USE_XCVR(1'b1), .CC_INIT_CLKS(4), .HOTPLUG_BITS(4)) i_dut (.clk, .srst, .masterRstN,
      .slaveRstN, .txData, .txClk, .rxData, .rxClk, .txDataSe, .txDataP, .txDataN, .txClkSe, .txClkP,
      .txClkN, .rxDataSe, .rxDataP, .rxClkSe, .rxClkP, .xcvrInitIn, .xcvrInitOut, .xcvrInitClk,
      .xcvrNotLocked, .xcvrChannelUp, .xcvrLogicReset, .clkCompPulseOut, .peerReady, .peerCfgBad,
      .multiBitErr, .peerIrqRx, .peerIrqTx, .linkUpOut, .linkFaultIrq, .multibitFaultIrq, .cfgMismatchIrq,
      .fwdLevelIrqIn, .revLevelIrqIn, .fwdLevelIrqOut, .revLevelIrqOut, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   cls_xcvr_peer i_peer (.clk, .lockOk, .slow, .badCfg, .bitErr, .irqLvl, .xcvrLogicReset, .xcvrInitClk,
      .xcvrNotLocked, .xcvrChannelUp, .peerReady, .peerCfgBad, .multiBitErr, .peerIrqRx);
   // 200 MHz system clock
   always #2.5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // poll one output bit a bounded number of cycles, then hand back at a rising edge
   task automatic waitBit(input int i, input logic v, input int lim);
      int n;
      n = 0;
      @(negedge clk);
      while (obs[i] !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk($sformatf("out%0d", i), {31'h0, obs[i]}, {31'h0, v});
      @(posedge clk);
   endtask
   // one register access; ready is read on the falling edge, so each release follows the taking edge
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, ar, done;
      logic [1:0] rsp;
      logic [31:0] rd;
      aw = wr;
      w = wr;
      ar = !wr;
      done = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_arvalid <= !wr;
      s_axi_bready <= wr;
      s_axi_rready <= !wr;
      while (!done) begin
         @(negedge clk);
         if (aw && s_axi_awready) aw = 1'b0;
         if (w && s_axi_wready) w = 1'b0;
         if (ar && s_axi_arready) ar = 1'b0;
         done = wr ? s_axi_bvalid : s_axi_rvalid;
         rsp = wr ? s_axi_bresp : s_axi_rresp;
         rd = s_axi_rdata;
         @(posedge clk);
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
         s_axi_arvalid <= ar;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      chk("resp", {30'h0, rsp}, {30'h0, er});
      if (!wr) chk("rdata", rd, d);
   endtask
   task automatic giveVerdict;
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clk);
      badCount++;
      giveVerdict();
   end
   // main sequence
   initial begin
      int n;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      acc(1'b0, `CLS_ADDR_CTRL, 32'h1, `CLS_RESP_OKAY);
      acc(1'b0, `CLS_ADDR_STATUS, 32'h10, `CLS_RESP_OKAY);
      acc(1'b1, 8'h0c, 32'h5, `CLS_RESP_SLVERR);
      acc(1'b0, 8'h0c, 32'h0, `CLS_RESP_SLVERR);
      @(negedge clk);
      chk("lanes", {txDataSe, txDataP, rxData, txClkSe, txClkP, rxClk}, {4'ha, 4'h0, 4'h5, 3'h5});
      chk("lanesN", {txDataN, txClkN, fwdLevelIrqOut}, 6'h00);
      waitBit(7, 1'b1, 40);
      $display("test registers and lanes done");
      masterRstN <= 1'b1;
      slaveRstN <= 1'b1;
      repeat (30) @(posedge clk);
      waitBit(2, 1'b0, 0);
      lockOk <= 1'b1;
      waitBit(2, 1'b1, 100);
      acc(1'b0, `CLS_ADDR_STATUS, 32'h27, `CLS_RESP_OKAY);
      waitBit(6, 1'b1, 100);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!obs[6] && n < 100);
      chk("ccGap", n, 32);
      $display("test link up done");
      irqLvl <= 1'b1;
      fwdLevelIrqIn <= 1'b1;
      waitBit(1, 1'b1, 8);
      waitBit(0, 1'b1, 8);
      irqLvl <= 1'b0;
      waitBit(1, 1'b0, 8);
      bitErr <= 1'b1;
      @(posedge clk);
      bitErr <= 1'b0;
      waitBit(3, 1'b1, 4);
      acc(1'b0, `CLS_ADDR_FAULT, 32'h2, `CLS_RESP_OKAY);
      acc(1'b1, `CLS_ADDR_FAULT, 32'h2, `CLS_RESP_OKAY);
      acc(1'b0, `CLS_ADDR_FAULT, 32'h0, `CLS_RESP_OKAY);
      $display("test levels and faults done");
      slaveRstN <= 1'b0;
      waitBit(2, 1'b0, 6);
      waitBit(4, 1'b1, 6);
      slow <= 1'b0;
      badCfg <= 1'b1;
      slaveRstN <= 1'b1;
      waitBit(5, 1'b1, 100);
      waitBit(2, 1'b0, 0);
      xcvrInitIn <= 1'b1;
      waitBit(7, 1'b1, 6);
      waitBit(8, 1'b1, 6);
      xcvrInitIn <= 1'b0;
      $display("test slave reset and config done");
      srst <= 1'b1;
      waitBit(4, 1'b0, 2);
      waitBit(5, 1'b0, 2);
      srst <= 1'b0;
      $display("test reset done");
      giveVerdict();
   end
endmodule // test_cls_sideband
